// [rtl/ctl_role_pkg.sv]
package ctl_role_pkg;
    // sentinel readings for a failed measurement
    localparam logic [63:0] SENTINEL_REAL = 64'h7fef_ffff_ffff_ffff;
    localparam logic [31:0] SENTINEL_INT = 32'h7fff_ffff;
    // register offsets
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_PASSBACK = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_COMMAND = 4'h3;
    // config fields
    localparam int CFG_SYSCTL = 0;
    localparam int CFG_RELEASE = 1;
    // passback fields
    localparam int PB_SEC_VALID = 10;
    localparam logic [4:0] PB_MAX = 5'h1e;
    // command fields (write-one pulses)
    localparam int CMD_RELEASE_ON = 0;
    localparam int CMD_PASS = 1;
    // reset values
    localparam logic CFG_RELEASE_RST = 1'b1;
    localparam logic [4:0] PB_PRIMARY_RST = 5'h00;
    // idle timeout
    localparam int IDLE_TIMEOUT_S = 10;
    localparam int CLOCK_HZ = 200_000_000;
    localparam longint IDLE_CYCLES = longint'(IDLE_TIMEOUT_S) * longint'(CLOCK_HZ);
    // controller role states
    typedef enum logic [2:0] {
        ROLE_IDLE = 3'b001,
        ROLE_ACTIVE = 3'b010,
        ROLE_PASSING = 3'b100
    } role_e;
endpackage

// [rtl/controller_role.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - failed measurement returns max sentinel reading
// - release feature on after reset
// - command turns release feature on
// - only system controller drives IFC
// - one system controller per bus
// - system controller active after reset/IFC; code: reset clears sysCtl_ff, role goes active once a config write sets it
// - handover: talk address, then TCT
// - acceptor active, previous becomes non-active
// - system controller active, indicator shown
// - talk addressed plus TCT grants control
// - active role before driving devices
// - pass back to stored address, default zero
// - script pause/end/reset returns control
// - IFC from system controller drops control
// - idle ten seconds returns control
// - finished controller command returns control
// - script pass instruction returns control
// - pass-back address limited to 0..30
// - two numbers: primary then secondary
module controller_role
    import ctl_role_pkg::*;
#(
    parameter longint IDLE_LIMIT = IDLE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // bus events decoded by the interface (pins, already synchronous)
    input wire logic ifcIn,
    input wire logic talkAddressed,
    input wire logic tctReceived,
    // bus actions
    output logic ifcOut,
    output logic ifcOe_n,
    output logic sendTct,
    output logic [4:0] tctPrimary,
    output logic [4:0] tctSecondary,
    output logic tctSecValid,
    // script and controller-command events
    input wire logic scriptRunning,
    input wire logic scriptPause,
    input wire logic scriptEnd,
    input wire logic scriptReset,
    input wire logic ctlCmdRequest,
    input wire logic ctlCmdDone,
    output logic ctlCmdGrant,
    // measurement result path
    input wire logic measFail,
    input wire logic measValid,
    input wire logic measIsInt,
    input wire logic [63:0] measData,
    output logic [63:0] resultData,
    output logic resultValid,
    // front-panel indicator
    output logic activeInd
);

    localparam int IDLE_W = 40;

    role_e state_ff, nxt_state;
    logic sysCtl_ff;
    logic release_ff;
    logic [4:0] pbPrimary_ff;
    logic [4:0] pbSecondary_ff;
    logic pbSecValid_ff;
    logic [IDLE_W-1:0] idle_ff;
    logic ifcPulse_ff;
    logic [63:0] result_ff;
    logic resultValid_ff;
    logic [15:0] rdData_ff;
    logic wrCfg, wrPb, wrCmd;
    logic giveBack;
    logic idleExpired;
    logic ifcSeen;

    // write decode
    assign wrCfg = regWrite && (regAddr == OFS_CONFIG);
    assign wrPb = regWrite && (regAddr == OFS_PASSBACK);
    assign wrCmd = regWrite && (regAddr == OFS_COMMAND);

    // configuration: system controller flag and release feature
    always_ff @(posedge clock) begin
        if (reset) begin
            sysCtl_ff <= 1'b0;
            release_ff <= CFG_RELEASE_RST;
        end else begin
            if (wrCfg) begin
                sysCtl_ff <= regWrData[CFG_SYSCTL];
                release_ff <= regWrData[CFG_RELEASE];
            end else if (wrCmd && regWrData[CMD_RELEASE_ON]) begin
                release_ff <= 1'b1;
            end
        end
    end

    // release feature is on and the role is idle right after reset
    property p_release_reset;
        @(posedge clock)
        ($past(reset) && !reset) |-> release_ff && !sysCtl_ff && !activeInd;
    endproperty
    a_release_reset: assert property (p_release_reset) else $error("release off");

    property p_release_cmd;
        @(posedge clock) disable iff (reset)
        (wrCmd && regWrData[CMD_RELEASE_ON]) |=> release_ff;
    endproperty
    a_release_cmd: assert property (p_release_cmd) else $error("cmd ignored");

    // pass-back address storage; out-of-range primary is clamped
    always_ff @(posedge clock) begin
        if (reset) begin
            pbPrimary_ff <= PB_PRIMARY_RST;
            pbSecondary_ff <= 5'h00;
            pbSecValid_ff <= 1'b0;
        end else if (wrPb) begin
            pbPrimary_ff <= (regWrData[4:0] > PB_MAX) ? PB_MAX : regWrData[4:0];
            pbSecondary_ff <= regWrData[9:5];
            pbSecValid_ff <= regWrData[PB_SEC_VALID];
        end
    end

    // each pass-back write replaces the whole return address
    property p_pb_sec_set;
        @(posedge clock) disable iff (reset)
        (wrPb && regWrData[PB_SEC_VALID]) |=> tctSecValid;
    endproperty
    a_pb_sec_set: assert property (p_pb_sec_set) else $error("sec lost");

    property p_pb_sec_clear;
        @(posedge clock) disable iff (reset)
        (wrPb && !regWrData[PB_SEC_VALID]) |=> !tctSecValid;
    endproperty
    a_pb_sec_clear: assert property (p_pb_sec_clear) else $error("stale sec");

    property p_pb_clamp;
        @(posedge clock) disable iff (reset)
        (wrPb && regWrData[4:0] > PB_MAX) |=> tctPrimary == PB_MAX;
    endproperty
    a_pb_clamp: assert property (p_pb_clamp) else $error("no clamp");

    // IFC asserted by the system controller for one cycle after a config write sets sysCtl from 0 to 1
    always_ff @(posedge clock) begin
        if (reset) begin
            ifcPulse_ff <= 1'b0;
        end else begin
            ifcPulse_ff <= wrCfg && regWrData[CFG_SYSCTL] && !sysCtl_ff;
        end
    end
    assign ifcOut = ifcPulse_ff && sysCtl_ff;
    assign ifcOe_n = !(ifcPulse_ff && sysCtl_ff);
    // an IFC seen from another system controller
    assign ifcSeen = ifcIn && !sysCtl_ff;

    // a non-system controller never drives IFC, and a drive lasts one cycle
    property p_ifc_quiet;
        @(posedge clock) disable iff (reset)
        !sysCtl_ff |-> ifcOe_n && !ifcOut;
    endproperty
    a_ifc_quiet: assert property (p_ifc_quiet) else $error("stray ifc");

    property p_ifc_single;
        @(posedge clock) disable iff (reset)
        ifcOut |=> !ifcOut;
    endproperty
    a_ifc_single: assert property (p_ifc_single) else $error("long ifc");

    // idle timer runs while active with no script and no command request
    assign idleExpired = (idle_ff >= IDLE_W'(IDLE_LIMIT));
    always_ff @(posedge clock) begin
        if (reset || state_ff != ROLE_ACTIVE || scriptRunning || ctlCmdRequest) begin
            idle_ff <= '0;
        end else if (!idleExpired) begin
            idle_ff <= idle_ff + IDLE_W'(1);
        end
    end

    // idle timer stops at its limit instead of wrapping
    property p_idle_cap;
        @(posedge clock) disable iff (reset)
        idle_ff <= IDLE_W'(IDLE_LIMIT);
    endproperty
    a_idle_cap: assert property (p_idle_cap) else $error("idle overrun");

    // reasons to hand control back
    always_comb begin
        giveBack = 1'b0;
        if (!sysCtl_ff) begin
            if (scriptRunning) begin
                giveBack = scriptPause || scriptEnd || scriptReset;
            end else begin
                giveBack = idleExpired || ctlCmdDone;
            end
            if (wrCmd && regWrData[CMD_PASS]) begin
                giveBack = 1'b1;
            end
        end
    end

    // each give-back reason is followed by a TCT cycle
    logic canPass;
    assign canPass = activeInd && !sysCtl_ff && !ctlCmdRequest && !ifcSeen;
    property p_idle_back;
        @(posedge clock) disable iff (reset)
        (canPass && !scriptRunning && idleExpired) |=> sendTct;
    endproperty
    a_idle_back: assert property (p_idle_back) else $error("idle no pass");

    property p_done_back;
        @(posedge clock) disable iff (reset)
        (canPass && !scriptRunning && ctlCmdDone) |=> sendTct;
    endproperty
    a_done_back: assert property (p_done_back) else $error("done no pass");

    property p_script_back;
        @(posedge clock) disable iff (reset)
        (canPass && scriptRunning && (scriptPause || scriptEnd || scriptReset)) |=> sendTct;
    endproperty
    a_script_back: assert property (p_script_back) else $error("script no pass");

    property p_pass_cmd;
        @(posedge clock) disable iff (reset)
        (canPass && wrCmd && regWrData[CMD_PASS]) |=> sendTct;
    endproperty
    a_pass_cmd: assert property (p_pass_cmd) else $error("cmd no pass");

    property p_sys_keeps;
        @(posedge clock) disable iff (reset)
        (activeInd && sysCtl_ff) |=> activeInd;
    endproperty
    a_sys_keeps: assert property (p_sys_keeps) else $error("sys lost role");

    // role state machine
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ROLE_IDLE: begin
                if (sysCtl_ff) begin
                    nxt_state = ROLE_ACTIVE;
                end else if (talkAddressed && tctReceived) begin
                    nxt_state = ROLE_ACTIVE;
                end
            end
            ROLE_ACTIVE: begin
                if (ifcSeen) begin
                    nxt_state = ROLE_IDLE;
                end else if (giveBack && !ctlCmdRequest) begin
                    nxt_state = ROLE_PASSING;
                end
            end
            ROLE_PASSING: begin
                nxt_state = ROLE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= ROLE_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // exactly one role at a time
    property p_state_hot;
        @(posedge clock) disable iff (reset)
        $onehot(state_ff);
    endproperty
    a_state_hot: assert property (p_state_hot) else $error("bad state");

    // TCT to the stored return address
    assign sendTct = (state_ff == ROLE_PASSING);
    assign tctPrimary = pbPrimary_ff;
    assign tctSecondary = pbSecondary_ff;
    assign tctSecValid = pbSecValid_ff;
    // external device access only while active
    assign ctlCmdGrant = ctlCmdRequest && (state_ff == ROLE_ACTIVE);
    assign activeInd = (state_ff == ROLE_ACTIVE);

    // measurement result with sentinel substitution
    always_ff @(posedge clock) begin
        if (reset) begin
            result_ff <= 64'h0;
            resultValid_ff <= 1'b0;
        end else begin
            resultValid_ff <= measValid || (measFail && release_ff);
            if (measFail && release_ff) begin
                result_ff <= measIsInt ? {32'h0, SENTINEL_INT} : SENTINEL_REAL;
            end else if (measValid) begin
                result_ff <= measData;
            end
        end
    end
    assign resultData = result_ff;
    assign resultValid = resultValid_ff;

    // integer sentinel and plain pass-through of good readings
    property p_sentinel_int;
        @(posedge clock) disable iff (reset)
        (measFail && release_ff && measIsInt) |=> resultValid && resultData == {32'h0, SENTINEL_INT};
    endproperty
    a_sentinel_int: assert property (p_sentinel_int) else $error("no int sentinel");

    property p_result_pass;
        @(posedge clock) disable iff (reset)
        (measValid && !measFail) |=> resultValid && resultData == $past(measData);
    endproperty
    a_result_pass: assert property (p_result_pass) else $error("bad result");

    // register read, data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            rdData_ff <= 16'h0;
        end else if (regRead) begin
            case (regAddr)
                OFS_CONFIG: rdData_ff <= {14'h0, release_ff, sysCtl_ff};
                OFS_PASSBACK: rdData_ff <= {5'h0, pbSecValid_ff, pbSecondary_ff, pbPrimary_ff};
                OFS_STATUS: rdData_ff <= {13'h0, state_ff};
                default: rdData_ff <= 16'h0;
            endcase
        end else begin
            rdData_ff <= 16'h0;
        end
    end
    assign regRdData = rdData_ff;

    // checks
    property p_tct_follows_talk;
        @(posedge clock) disable iff (reset)
        (state_ff == ROLE_IDLE && !sysCtl_ff && talkAddressed && tctReceived) |=> activeInd;
    endproperty
    a_tct_follows_talk: assert property (p_tct_follows_talk) else $error("tct not accepted");

    property p_ifc_drop;
        @(posedge clock) disable iff (reset)
        (activeInd && ifcSeen) |=> !activeInd;
    endproperty
    a_ifc_drop: assert property (p_ifc_drop) else $error("ifc ignored");

    property p_pass_then_idle;
        @(posedge clock) disable iff (reset)
        sendTct |=> (state_ff == ROLE_IDLE) && !sendTct;
    endproperty
    a_pass_then_idle: assert property (p_pass_then_idle) else $error("tct not single");

    property p_sentinel;
        @(posedge clock) disable iff (reset)
        (measFail && release_ff && !measIsInt) |=> resultValid && resultData == SENTINEL_REAL;
    endproperty
    a_sentinel: assert property (p_sentinel) else $error("no sentinel");

    property p_grant_active;
        @(posedge clock) disable iff (reset)
        ctlCmdGrant |-> activeInd;
    endproperty
    a_grant_active: assert property (p_grant_active) else $error("grant while inactive");

    property p_ifc_only_sys;
        @(posedge clock) disable iff (reset)
        ifcOut |-> sysCtl_ff && !ifcOe_n;
    endproperty
    a_ifc_only_sys: assert property (p_ifc_only_sys) else $error("ifc by non-system");

    property p_sys_active;
        @(posedge clock) disable iff (reset)
        $rose(sysCtl_ff) |-> ##[0:2] activeInd;
    endproperty
    a_sys_active: assert property (p_sys_active) else $error("system not active");

    property p_pb_range;
        @(posedge clock) disable iff (reset)
        tctPrimary <= PB_MAX;
    endproperty
    a_pb_range: assert property (p_pb_range) else $error("address out of range");

endmodule // controller_role

// [tb/far_controller.sv]
`timescale 1ns/1ps
module far_controller (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // requests from the bench
    input wire logic giveCtl,
    input wire logic assertIfc,
    // bus events toward the device
    output logic talkAddressed,
    output logic tctReceived,
    output logic ifcIn,
    // control handed back by the device
    input wire logic sendTct,
    input wire logic [4:0] tctPrimary,
    output int tctCount,
    output logic [4:0] tctAddr
);
    logic [1:0] step_ff;
    // talk address stands before, during and after the one TCT pulse
    always_ff @(posedge clock) begin
        if (reset) step_ff <= 2'h0;
        else if (giveCtl) step_ff <= 2'h1;
        else if (step_ff != 2'h0) step_ff <= step_ff + 2'h1;
    end
    assign talkAddressed = (step_ff != 2'h0);
    assign tctReceived = (step_ff == 2'h2);
    // this side is the only system controller, so only it raises IFC
    always_ff @(posedge clock) begin
        ifcIn <= !reset && assertIfc;
    end
    // take control back, remembering where it came to
    always_ff @(posedge clock) begin
        if (reset) begin
            tctCount <= 0;
            tctAddr <= 5'h1f;
        end else if (sendTct) begin
            tctCount <= tctCount + 1;
            tctAddr <= tctPrimary;
        end
    end
endmodule // far_controller

// [tb/gpib_controller_role_passing_test.sv]
`timescale 1ns/1ps
module gpib_controller_role_passing_test;
    import ctl_role_pkg::*;
    logic clock = 0, reset = 1, regWrite = 0, regRead = 0, giveCtl = 0, assertIfc = 0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0, regRdData;
    logic ifcIn, talkAddressed, tctReceived, ifcOut, ifcOe_n, sendTct, tctSecValid;
    logic [4:0] tctPrimary, tctSecondary, tctAddr;
    logic scriptRunning = 0, scriptPause = 0, scriptEnd = 0, scriptReset = 0;
    logic ctlCmdRequest = 0, ctlCmdDone = 0, ctlCmdGrant, sawIfc = 0;
    logic measFail = 0, measValid = 0, measIsInt = 0, resultValid, activeInd;
    logic [63:0] measData = 64'h0123_4567_89ab_cdef, resultData;
    int n_fail = 0, checks = 0, tctCount, n;
    controller_role #(.IDLE_LIMIT(100)) u_controller_role (.clock(clock), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .ifcIn(ifcIn), .talkAddressed(talkAddressed),
        .tctReceived(tctReceived), .ifcOut(ifcOut), .ifcOe_n(ifcOe_n), .sendTct(sendTct),
        .tctPrimary(tctPrimary), .tctSecondary(tctSecondary), .tctSecValid(tctSecValid),
        .scriptRunning(scriptRunning), .scriptPause(scriptPause), .scriptEnd(scriptEnd),
        .scriptReset(scriptReset), .ctlCmdRequest(ctlCmdRequest), .ctlCmdDone(ctlCmdDone),
        .ctlCmdGrant(ctlCmdGrant), .measFail(measFail), .measValid(measValid),
        .measIsInt(measIsInt), .measData(measData), .resultData(resultData),
        .resultValid(resultValid), .activeInd(activeInd));
    far_controller u_far_controller (.clock(clock), .reset(reset), .giveCtl(giveCtl),
        .assertIfc(assertIfc), .talkAddressed(talkAddressed), .tctReceived(tctReceived),
        .ifcIn(ifcIn), .sendTct(sendTct), .tctPrimary(tctPrimary), .tctCount(tctCount),
        .tctAddr(tctAddr));
    // clock and a sticky flag for a driven IFC pulse
    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (ifcOut === 1'b1 && ifcOe_n === 1'b0) sawIfc <= 1'b1;
    end
    task automatic check(input string what, input logic [63:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdChk(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 check(what, {48'h0, regRdData}, {48'h0, exp});
    endtask
    task automatic passIn();
        @(posedge clock);
        giveCtl <= 1'b1;
        @(posedge clock);
        giveCtl <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic waitTct(input int lim);
        int c0;
        c0 = tctCount;
        n = 0;
        while (tctCount == c0 && n < lim) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic failMeas(input logic f, isInt, v, input logic [63:0] exp);
        @(posedge clock);
        measFail <= f;
        measValid <= !f;
        measIsInt <= isInt;
        @(posedge clock);
        {measFail, measValid} <= 2'b00;
        #1 check("resultValid", {63'h0, resultValid}, {63'h0, v});
        check("resultData", resultData, exp);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        rdChk("config", OFS_CONFIG, 16'h0002);
        check("ifcOe_n", {62'h0, ifcOe_n, ifcOut}, 64'h2);
        rdChk("passback", OFS_PASSBACK, 16'h0000);
        rdChk("status", OFS_STATUS, {13'h0, ROLE_IDLE});
        rdChk("unmapped", 4'hf, 16'h0000);
        failMeas(1'b1, 1'b0, 1'b1, SENTINEL_REAL);
        failMeas(1'b1, 1'b1, 1'b1, {32'h0, SENTINEL_INT});
        failMeas(1'b0, 1'b0, 1'b1, 64'h0123_4567_89ab_cdef);
        wrReg(OFS_CONFIG, 16'h0000);
        failMeas(1'b1, 1'b0, 1'b0, 64'h0123_4567_89ab_cdef);
        wrReg(OFS_COMMAND, 16'h0001);
        rdChk("config", OFS_CONFIG, 16'h0002);
        $display("test reset and sentinel done");
        // pass-back address is written before control is handed over
        wrReg(OFS_PASSBACK, 16'h04bf);
        rdChk("passback", OFS_PASSBACK, 16'h04be);
        check("tctSecondary", {58'h0, tctSecValid, tctSecondary}, 64'h25);
        wrReg(OFS_PASSBACK, 16'h0007);
        rdChk("passback", OFS_PASSBACK, 16'h0007);
        check("tctSecValid", {63'h0, tctSecValid}, 64'h0);
        passIn();
        #1 check("activeInd", {63'h0, activeInd}, 64'h1);
        rdChk("status", OFS_STATUS, {13'h0, ROLE_ACTIVE});
        @(posedge clock);
        ctlCmdRequest <= 1'b1;
        @(posedge clock);
        #1 check("ctlCmdGrant", {63'h0, ctlCmdGrant}, 64'h1);
        @(posedge clock);
        ctlCmdRequest <= 1'b0;
        ctlCmdDone <= 1'b1;
        @(posedge clock);
        ctlCmdDone <= 1'b0;
        waitTct(10);
        check("tctAddr", {59'h0, tctAddr}, 64'h7);
        check("doneQuick", {63'h0, n < 10}, 64'h1);
        $display("test command give-back done");
        passIn();
        waitTct(300);
        check("idleSpan", {63'h0, n >= 90 && n <= 104}, 64'h1);
        $display("test idle give-back done");
        scriptRunning <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            passIn();
            if (k == 3) wrReg(OFS_COMMAND, 16'h0002);
            else begin
                @(posedge clock);
                scriptPause <= (k == 0);
                scriptEnd <= (k == 1);
                scriptReset <= (k == 2);
                @(posedge clock);
                {scriptPause, scriptEnd, scriptReset} <= 3'b000;
            end
            waitTct(10);
            check("scriptBack", {63'h0, n < 10}, 64'h1);
        end
        scriptRunning <= 1'b0;
        $display("test script give-back done");
        passIn();
        assertIfc <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check("activeInd", {63'h0, activeInd}, 64'h0);
        @(posedge clock);
        assertIfc <= 1'b0;
        repeat (3) @(posedge clock);
        wrReg(OFS_CONFIG, 16'h0003);
        repeat (4) @(posedge clock);
        #1 check("sawIfc", {63'h0, sawIfc}, 64'h1);
        check("activeInd", {63'h0, activeInd}, 64'h1);
        rdChk("status", OFS_STATUS, {13'h0, ROLE_ACTIVE});
        $display("test system controller done");
        report_and_stop();
    end
endmodule // gpib_controller_role_passing_test
